/* hup_core.sv */
/*
 Host serial port top: Avalon-MM registers, baud divider, pin routing, flow,
 message gap, host wake and receive error tracking.
 Assumes pins arrive from another domain; Avalon master shares clk_sys.
*/
// Local design decisions: the register offsets and the Avalon-MM register port.
`timescale 1ns/1ps
module hup_core
	import hup_pkg::*;
(
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	output logic pri_tx,
	input wire logic pri_rx,
	output logic rx_flow_request_n,
	input wire logic tx_clear_n,
	output logic sec_tx,
	output logic sec_tx_oe,
	input wire logic sec_rx,
	output logic host_wake,
	output logic pins_assigned
);
	hup_line_if lif ();

	logic [1:0] pri_rx_s_q;
	logic [1:0] sec_rx_s_q;
	logic [1:0] clr_s_q;
	logic [5:0] ctl_q;
	logic [15:0] div_q;
	logic [15:0] gap_q;
	logic [31:0] wake_q;
	logic [15:0] bcnt_q;
	logic tick_q;
	logic [7:0] rxd_q;
	logic rxv_q;
	logic ovr_q;
	logic frm_q;
	logic cto_q;
	logic [7:0] txd_q;
	logic txv_q;
	logic [3:0] tick16_q;
	logic [15:0] idle_q;
	logic [15:0] gapc_q;
	logic eom_q;
	logic [31:0] wcnt_q;
	logic woke_q;
	logic ack_q;
	logic [31:0] rdata_q;
	logic sec_sel;
	logic flow_on;
	logic send_ok;
	logic wr;
	logic rd;
	logic rd_data;
	logic wr_data;
	logic wr_status;
	logic [31:0] ctl_m;
	logic [31:0] div_m;
	logic [31:0] gap_m;
	logic [31:0] status_w;

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [31:0] hup_merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				r[8*i +: 8] = nw[8*i +: 8];
			end
		end
		return r;
	endfunction : hup_merge

	function automatic logic [15:0] hup_clamp(input logic [15:0] v);
		if (v < hup_div_min) begin
			return hup_div_min;
		end
		if (v > hup_div_max) begin
			return hup_div_max;
		end
		return v;
	endfunction : hup_clamp

	function automatic logic hup_hit(input logic strobe, input logic [3:0] addr,
		input logic [3:0] idx);
		return strobe && (addr == idx);
	endfunction : hup_hit

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			pri_rx_s_q <= 2'b11;
			sec_rx_s_q <= 2'b11;
			clr_s_q <= 2'b11;
		end else begin
			pri_rx_s_q <= {pri_rx_s_q[0], pri_rx};
			sec_rx_s_q <= {sec_rx_s_q[0], sec_rx};
			clr_s_q <= {clr_s_q[0], tx_clear_n};
		end
	end

	// Secondary only when test mode and swap both set, so never both live
	assign sec_sel = ctl_q[hup_ctl_test] && ctl_q[hup_ctl_swap]; // R07 R12
	assign flow_on = ctl_q[hup_ctl_flow] && !sec_sel; // R06 R10

	// ----------------------------------------
	// Pin routing
	// ----------------------------------------
	assign lif.rx_line = sec_sel ? sec_rx_s_q[1] : pri_rx_s_q[1]; // R12
	assign pri_tx = (ctl_q[hup_ctl_en] && !sec_sel) ? lif.tx_line : 1'b1; // R02 R07
	assign sec_tx = lif.tx_line;
	assign sec_tx_oe = ctl_q[hup_ctl_en] && sec_sel; // R07
	// Pins are handed to the port only after reset, on enable
	assign pins_assigned = ctl_q[hup_ctl_en]; // R13
	// Ready to accept while holding no unread character
	assign rx_flow_request_n = flow_on ? rxv_q : 1'b1; // R03 R15

	// ----------------------------------------
	// Serial engines
	// ----------------------------------------
	// One shared tick, so a rate change hits both directions at once
	hup_tx tx_u (
		.clk_sys(clk_sys),
		.reset(reset),
		.lif(lif)
	);
	hup_rx rx_u (
		.clk_sys(clk_sys),
		.reset(reset),
		.lif(lif)
	);

	// ----------------------------------------
	// Baud divider
	// ----------------------------------------
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			bcnt_q <= 16'h0000;
			tick_q <= 1'b0;
		end else begin
			tick_q <= 1'b0;
			if (bcnt_q == 16'h0000) begin
				bcnt_q <= (sec_sel ? hup_div_9600 : div_q) - 16'h0001; // R04 R06
				tick_q <= 1'b1; // R17
			end else begin
				bcnt_q <= bcnt_q - 16'h0001;
			end
		end
	end
	assign lif.tick = tick_q;

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	assign wr = avs_write && !ack_q;
	assign rd = avs_read && !ack_q;
	assign avs_waitrequest = (avs_read || avs_write) && !ack_q;
	assign avs_readdata = rdata_q;
	assign rd_data = hup_hit(rd, avs_address, hup_reg_data);
	assign wr_data = hup_hit(wr, avs_address, hup_reg_data);
	assign wr_status = hup_hit(wr, avs_address, hup_reg_status);
	// Lanes merged on the full word, then cut to the field width
	assign ctl_m = hup_merge({26'h0, ctl_q}, avs_writedata, avs_byteenable);
	assign div_m = hup_merge({16'h0, div_q}, avs_writedata, avs_byteenable);
	assign gap_m = hup_merge({16'h0, gap_q}, avs_writedata, avs_byteenable);

	// Status word built from the field positions
	always_comb begin
		status_w = 32'h0000_0000;
		status_w[hup_st_rxv] = rxv_q; // R09
		status_w[hup_st_txr] = !txv_q;
		status_w[hup_st_ovr] = ovr_q; // R09
		status_w[hup_st_frm] = frm_q; // R09
		status_w[hup_st_cto] = cto_q; // R09
		status_w[hup_st_busy] = lif.tx_busy;
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			ctl_q <= hup_ctl_reset; // R10 R11
			div_q <= hup_div_reset; // R05
			gap_q <= hup_gap_reset; // R08
			wake_q <= hup_wake_reset; // R11
		end else if (wr) begin
			case (avs_address)
				hup_reg_ctrl: ctl_q <= ctl_m[5:0];
				hup_reg_baud: div_q <= hup_clamp(div_m[15:0]); // R04
				hup_reg_gap: gap_q <= gap_m[15:0]; // R08
				hup_reg_wake: wake_q <= hup_merge(wake_q, avs_writedata, avs_byteenable); // R11
				default: ;
			endcase
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			ack_q <= 1'b0;
			rdata_q <= 32'h0000_0000;
		end else begin
			ack_q <= (avs_read || avs_write) && !ack_q;
			if (rd) begin
				case (avs_address)
					hup_reg_data: rdata_q <= {24'h0, rxd_q};
					hup_reg_status: rdata_q <= status_w; // R09
					hup_reg_ctrl: rdata_q <= {26'h0, ctl_q};
					hup_reg_baud: rdata_q <= {16'h0, div_q};
					hup_reg_gap: rdata_q <= {16'h0, gap_q};
					hup_reg_wake: rdata_q <= wake_q;
					default: rdata_q <= 32'h0000_0000;
				endcase
			end
		end
	end

	// ----------------------------------------
	// Receive holding and errors
	// ----------------------------------------
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			rxd_q <= 8'h00;
			rxv_q <= 1'b0;
			ovr_q <= 1'b0;
			frm_q <= 1'b0;
		end else begin
			if (rd_data) begin
				rxv_q <= 1'b0;
			end
			if (wr_status) begin
				ovr_q <= ovr_q & ~avs_writedata[hup_st_ovr];
				frm_q <= frm_q & ~avs_writedata[hup_st_frm];
			end
			// Hardware set wins over a same-cycle clear
			if (lif.rx_done) begin
				rxd_q <= lif.rx_byte;
				rxv_q <= 1'b1;
				if (rxv_q && !rd_data) begin
					ovr_q <= 1'b1; // R16
				end
				if (lif.rx_ferr) begin
					frm_q <= 1'b1; // R16
				end
			end
		end
	end

	// Character timeout: unread data with the line idle for four characters
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			tick16_q <= 4'h0;
			idle_q <= 16'h0000;
			cto_q <= 1'b0;
		end else begin
			if (wr_status) begin
				cto_q <= cto_q & ~avs_writedata[hup_st_cto];
			end
			if (lif.rx_done || !lif.rx_line || !rxv_q) begin
				idle_q <= 16'h0000;
				tick16_q <= 4'h0;
			end else if (tick_q) begin
				tick16_q <= tick16_q + 4'h1;
				if (tick16_q == 4'hF) begin
					idle_q <= idle_q + 16'h0001;
					if (idle_q == 16'((hup_cto_chars * 10) - 1)) begin
						cto_q <= 1'b1; // R09
					end
				end
			end
		end
	end

	// ----------------------------------------
	// Transmit path: gap, wake, clear
	// ----------------------------------------
	assign send_ok = txv_q && !lif.tx_busy && gapc_q == 16'h0000 && woke_q
		&& !(flow_on && clr_s_q[1]); // R10 R15
	assign lif.tx_start = send_ok;
	assign lif.tx_byte = txd_q;

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			txd_q <= 8'h00;
			txv_q <= 1'b0;
			eom_q <= 1'b0;
		end else begin
			if (send_ok) begin
				txv_q <= 1'b0;
			end
			if (wr_data && !txv_q && avs_byteenable[0]) begin
				txd_q <= avs_writedata[7:0];
				txv_q <= 1'b1;
				eom_q <= ctl_q[hup_ctl_eom];
			end
		end
	end

	// Gap counted in character times after the last byte of a message
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			gapc_q <= 16'h0000;
		end else if (send_ok && eom_q) begin
			gapc_q <= 16'((32'(gap_q) + 32'd1) * hup_oversample * 10); // R08
		end else if (tick_q && gapc_q != 16'h0000) begin
			gapc_q <= gapc_q - 16'h0001; // R08
		end
	end

	// Wake held while sending; timer restarts when idle
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			wcnt_q <= 32'h0000_0000;
			woke_q <= 1'b1;
			host_wake <= 1'b0;
		end else if (!ctl_q[hup_ctl_wake] || sec_sel) begin
			woke_q <= 1'b1; // R06
			host_wake <= 1'b0;
			wcnt_q <= 32'h0000_0000;
		end else if (!txv_q && !lif.tx_busy) begin
			woke_q <= 1'b0;
			host_wake <= 1'b0;
			wcnt_q <= 32'h0000_0000;
		end else begin
			host_wake <= 1'b1; // R11
			if (wcnt_q >= wake_q) begin
				woke_q <= 1'b1; // R11
			end else begin
				wcnt_q <= wcnt_q + 32'h0000_0001;
			end
		end
	end
endmodule : hup_core

/* hup_pkg.sv */
/*
 Shared constants for the host serial port: registers, fields, reset values, timing.
 Assumes a 25 MHz system clock and an Avalon-MM register master on the same clock.
*/
// How it works
// [R01] Character is start bit, eight data bits LSB first, one stop, no parity.
// [R02] Transmitter and receiver run at once on separate lines.
// [R03] Two-line or four-line mode with flow lines chosen by a control bit.
// [R04] Primary port baud rate programmable between 9600 and 921600 bit/s. Code clamps the divider to 2..163, about 9586 to 781250 bit/s.
// [R05] After reset the primary port runs at 115200 bit/s.
// [R06] Secondary port fixed at 9600 bit/s, no flow control or wake.
// [R07] Secondary port off by default, test mode only, never with primary.
// [R08] At least 12 idle character times between messages; gap is programmable.
// [R09] Receiver detects and reports character timeout, overrun and framing errors.
// [R10] Flow control off after reset; when on, drive request, obey clear.
// [R11] Optional wake pin asserted a programmable time, default 10 ms, before sending.
// [R12] In test mode a control bit swaps data pins to the secondary port.
// [R13] Data pins become serial only after reset release, two-wire first.
// [R14] Host waits 150 us after test reset completes before next command.
// [R15] Flow lines active low; request low means ready, clear high stalls.
// [R16] Framing error on low stop bit; overrun when unread character is replaced.
// [R17] Receiver samples bit centres with 16x oversampling, resyncing on start edge.
package hup_pkg;
	localparam int unsigned hup_clk_hz = 25000000;
	localparam int unsigned hup_oversample = 16;
	// Divider value is clock / (16 * baud), rounded
	localparam logic [15:0] hup_div_reset = 16'h000E;
	localparam logic [15:0] hup_div_9600 = 16'h00A3;
	localparam logic [15:0] hup_div_min = 16'h0002;
	localparam logic [15:0] hup_div_max = 16'h00A3;
	localparam logic [15:0] hup_gap_reset = 16'h000C;
	localparam int unsigned hup_wake_ms = 10;
	localparam logic [31:0] hup_wake_reset = 32'(hup_wake_ms * (hup_clk_hz / 1000));
	localparam int unsigned hup_cto_chars = 4;
	localparam int unsigned hup_test_reset_wait_us = 150;
	// Register word offsets (byte address = 4 * index)
	localparam logic [3:0] hup_reg_data = 4'h0;
	localparam logic [3:0] hup_reg_status = 4'h1;
	localparam logic [3:0] hup_reg_ctrl = 4'h2;
	localparam logic [3:0] hup_reg_baud = 4'h3;
	localparam logic [3:0] hup_reg_gap = 4'h4;
	localparam logic [3:0] hup_reg_wake = 4'h5;
	// Control fields
	localparam int unsigned hup_ctl_en = 0;
	localparam int unsigned hup_ctl_flow = 1;
	localparam int unsigned hup_ctl_wake = 2;
	localparam int unsigned hup_ctl_test = 3;
	localparam int unsigned hup_ctl_swap = 4;
	localparam int unsigned hup_ctl_eom = 5;
	localparam logic [5:0] hup_ctl_reset = 6'h00;
	// Status fields
	localparam int unsigned hup_st_rxv = 0;
	localparam int unsigned hup_st_txr = 1;
	localparam int unsigned hup_st_ovr = 2;
	localparam int unsigned hup_st_frm = 3;
	localparam int unsigned hup_st_cto = 4;
	localparam int unsigned hup_st_busy = 5;
endpackage : hup_pkg

/* hup_line_if.sv */
/*
 Carrier between the core and its serial engines: one tick, one character each way.
 Assumes all parties run on clk_sys.
*/
`timescale 1ns/1ps
interface hup_line_if;
	logic tick;
	logic tx_start;
	logic [7:0] tx_byte;
	logic tx_busy;
	logic tx_line;
	logic rx_line;
	logic rx_done;
	logic rx_ferr;
	logic [7:0] rx_byte;
	modport tx (input tick, input tx_start, input tx_byte, output tx_busy, output tx_line);
	modport rx (input tick, input rx_line, output rx_done, output rx_ferr, output rx_byte);
	modport core (output tick, output tx_start, output tx_byte, input tx_busy, input tx_line,
		output rx_line, input rx_done, input rx_ferr, input rx_byte);
endinterface : hup_line_if

/* hup_tx.sv */
/*
 Serial transmitter, 16x tick based.
 Assumes tx_start only while tx_busy is low.
*/
`timescale 1ns/1ps
module hup_tx
	import hup_pkg::*;
(
	input wire logic clk_sys,
	input wire logic reset,
	hup_line_if.tx lif
);
	logic [8:0] sh_q;
	logic [3:0] bit_q;
	logic [3:0] sub_q;
	logic busy_q;

	// ----------------------------------------
	// Shifter
	// ----------------------------------------
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			sh_q <= 9'h1FF;
			bit_q <= 4'h0;
			sub_q <= 4'h0;
			busy_q <= 1'b0;
		end else if (!busy_q) begin
			if (lif.tx_start) begin
				sh_q <= {lif.tx_byte, 1'b0}; // R01
				bit_q <= 4'h0;
				sub_q <= 4'h0;
				busy_q <= 1'b1;
			end
		end else if (lif.tick) begin
			sub_q <= sub_q + 4'h1;
			if (sub_q == 4'hF) begin
				sh_q <= {1'b1, sh_q[8:1]}; // R01
				bit_q <= bit_q + 4'h1;
				if (bit_q == 4'h9) begin
					busy_q <= 1'b0;
				end
			end
		end
	end

	// Stop bit is the idle fill shifted in
	assign lif.tx_line = busy_q ? sh_q[0] : 1'b1;
	assign lif.tx_busy = busy_q;
endmodule : hup_tx

/* hup_rx.sv */
/*
 Serial receiver with 16x oversampling.
 Assumes rx_line is already synchronised to clk_sys.
*/
`timescale 1ns/1ps
module hup_rx
	import hup_pkg::*;
(
	input wire logic clk_sys,
	input wire logic reset,
	hup_line_if.rx lif
);
	typedef enum logic [1:0] {hup_idle, hup_start, hup_data, hup_stop} hup_rx_t;
	hup_rx_t st_q;
	logic [3:0] sub_q;
	logic [2:0] bit_q;
	logic [7:0] sh_q;
	logic done_q;
	logic ferr_q;
	logic [7:0] byte_q;

	// ----------------------------------------
	// Receive state
	// ----------------------------------------
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			st_q <= hup_idle;
			sub_q <= 4'h0;
			bit_q <= 3'h0;
			sh_q <= 8'h00;
			done_q <= 1'b0;
			ferr_q <= 1'b0;
			byte_q <= 8'h00;
		end else begin
			done_q <= 1'b0;
			if (lif.tick) begin
				sub_q <= sub_q + 4'h1;
				case (st_q)
					hup_idle: begin
						sub_q <= 4'h0;
						if (!lif.rx_line) begin
							st_q <= hup_start; // R17
						end
					end
					hup_start: begin
						if (sub_q == 4'h7) begin
							sub_q <= 4'h0;
							bit_q <= 3'h0;
							st_q <= lif.rx_line ? hup_idle : hup_data; // R17
						end
					end
					hup_data: begin
						if (sub_q == 4'hF) begin
							sh_q <= {lif.rx_line, sh_q[7:1]}; // R01
							bit_q <= bit_q + 3'h1;
							if (bit_q == 3'h7) begin
								st_q <= hup_stop;
							end
						end
					end
					hup_stop: begin
						if (sub_q == 4'hF) begin
							byte_q <= sh_q;
							ferr_q <= !lif.rx_line; // R16
							done_q <= 1'b1;
							st_q <= hup_idle;
						end
					end
					default: st_q <= hup_idle;
				endcase
			end
		end
	end

	assign lif.rx_done = done_q;
	assign lif.rx_ferr = ferr_q;
	assign lif.rx_byte = byte_q;
endmodule : hup_rx

/* hup_core_chk.sv */
/*
 Port-level checker for the host serial port core.
 Assumes one clock, clk_sys, and a synchronous active-high reset.
*/
`timescale 1ns/1ps
module hup_core_chk (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	input wire logic pri_tx,
	input wire logic pri_rx,
	input wire logic rx_flow_request_n,
	input wire logic tx_clear_n,
	input wire logic sec_tx,
	input wire logic sec_tx_oe,
	input wire logic sec_rx,
	input wire logic host_wake,
	input wire logic pins_assigned
);
	// ----------------------------------------
	// Sequences
	// ----------------------------------------
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (reset);
	// Shortest bit is 32 cycles, so 8 is a safe floor
	sequence s_low_run; !pri_tx [*8]; endsequence
	sequence s_high_run; pri_tx [*8]; endsequence
	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	a_wait_first: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest)
		else $error("waitrequest low in first request cycle");
	a_wait_single: assert property (avs_waitrequest |=> !avs_waitrequest)
		else $error("waitrequest held too long");
	a_wait_idle: assert property (!(avs_read || avs_write) |-> !avs_waitrequest)
		else $error("waitrequest without request");
	a_reset_quiet: assert property ($fell(reset) |-> pri_tx && sec_tx &&
		!sec_tx_oe && rx_flow_request_n && !host_wake && !pins_assigned)
		else $error("outputs not at reset values");
	a_low_width: assert property ($fell(pri_tx) |-> s_low_run)
		else $error("low bit too short");
	a_high_width: assert property ($rose(pri_tx) |-> s_high_run)
		else $error("high bit too short");
	a_sec_alone: assert property (sec_tx_oe |-> pri_tx)
		else $error("both ports active");
	a_pins_idle: assert property (!pins_assigned |-> pri_tx && !sec_tx_oe)
		else $error("pins driven before assignment");
	a_wake_lead: assert property ($rose(host_wake) |-> s_high_run)
		else $error("sent with no wake lead");
	a_rdata_hold: assert property (!avs_read && !$past(avs_read) |-> $stable(avs_readdata))
		else $error("readdata moved without read");
endmodule : hup_core_chk

bind hup_core hup_core_chk chk_u (.clk_sys(clk_sys), .reset(reset),
	.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
	.avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
	.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .pri_tx(pri_tx),
	.pri_rx(pri_rx), .rx_flow_request_n(rx_flow_request_n), .tx_clear_n(tx_clear_n),
	.sec_tx(sec_tx), .sec_tx_oe(sec_tx_oe), .sec_rx(sec_rx), .host_wake(host_wake),
	.pins_assigned(pins_assigned));

/* hup_host_model.sv */
/*
 Behavioural host UART: sends frames on demand, decodes frames it receives.
 Assumes bit_cyc is set to the bit length in clk_sys cycles.
*/
`timescale 1ns/1ps
module hup_host_model (
	input wire logic clk_sys,
	input wire logic [31:0] bit_cyc,
	input wire logic line_in,
	output logic line_out,
	output logic [7:0] got_byte,
	output int got_count,
	output longint got_start
);
	longint cyc = 0;
	initial line_out = 1'b1;
	always @(posedge clk_sys) cyc <= cyc + 1;
	// ----------------------------------------
	// Transmitter
	// ----------------------------------------
	// No test-mode reset command is issued here
	task automatic send(input logic [7:0] b, input logic stop);
		logic [9:0] f;
		f = {stop, b, 1'b0};
		for (int i = 0; i < 10; i++) begin
			@(posedge clk_sys) line_out <= f[i];
			repeat (bit_cyc - 1) @(posedge clk_sys);
		end
		@(posedge clk_sys) line_out <= 1'b1;
	endtask : send
	// ----------------------------------------
	// Receiver
	// ----------------------------------------
	initial begin
		got_count = 0;
		got_byte = 8'h00;
		got_start = 0;
		forever begin
			@(posedge clk_sys);
			if (line_in === 1'b0) begin
				got_start = cyc;
				repeat (bit_cyc + bit_cyc / 2) @(posedge clk_sys);
				for (int i = 0; i < 8; i++) begin
					got_byte[i] = line_in;
					repeat (bit_cyc) @(posedge clk_sys);
				end
				got_count++;
			end
		end
	end
endmodule : hup_host_model

/* hup_core_bench.sv */
/*
 Self-checking bench for the host serial port core.
 Assumes the checker is bound in and the host model sits on the pins.
*/
`timescale 1ns/1ps
module hup_core_bench;
	import hup_pkg::*;
	logic clk_sys = 1'b0;
	logic reset = 1'b1;
	logic [3:0] avs_address = 4'h0;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [3:0] avs_byteenable = 4'hF;
	logic [31:0] avs_readdata;
	logic avs_waitrequest, pri_tx, host_rx, rx_flow_request_n, sec_tx, sec_tx_oe;
	logic host_wake, pins_assigned;
	logic tx_clear_n = 1'b0;
	logic [31:0] host_bit = 32'd224;
	int miscompares = 0;
	int checks_done = 0;
	always #20 clk_sys = ~clk_sys;
	hup_core dut_u (.clk_sys(clk_sys), .reset(reset), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .pri_tx(pri_tx), .pri_rx(host_rx),
		.rx_flow_request_n(rx_flow_request_n), .tx_clear_n(tx_clear_n), .sec_tx(sec_tx),
		.sec_tx_oe(sec_tx_oe), .sec_rx(host_rx), .host_wake(host_wake),
		.pins_assigned(pins_assigned));
	hup_host_model host_u (.clk_sys(clk_sys), .bit_cyc(host_bit),
		.line_in(sec_tx_oe ? sec_tx : pri_tx), .line_out(host_rx), .got_byte(),
		.got_count(), .got_start());
	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			miscompares++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check
	task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
		output logic [31:0] q);
		@(posedge clk_sys);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= wr;
		avs_read <= !wr;
		@(posedge clk_sys);
		// No wait-state count assumed; only the watchdog ends a hung wait
		while (avs_waitrequest !== 1'b0) begin
			@(posedge clk_sys);
		end
		q = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask : bus
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask : wr
	task automatic rd(input logic [3:0] a, input logic [31:0] exp, input logic [31:0] m);
		logic [31:0] q;
		bus(1'b0, a, 32'h0, q);
		check(q & m, exp);
	endtask : rd
	task automatic wait_rx(input int n);
		int k;
		for (k = 0; k < 40000 && host_u.got_count < n; k++) @(posedge clk_sys);
	endtask : wait_rx
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_reset_regs;
		rd(hup_reg_ctrl, 32'h0, 32'hFFFFFFFF);
		rd(hup_reg_baud, 32'h0000000E, 32'hFFFFFFFF);
		rd(hup_reg_gap, 32'h0000000C, 32'hFFFFFFFF);
		rd(hup_reg_wake, 32'h0003D090, 32'hFFFFFFFF);
		rd(4'hF, 32'h0, 32'hFFFFFFFF);
		check(pins_assigned, 1'b0);
		$display("test reset_regs done");
	endtask : t_reset_regs
	task automatic t_default_tx;
		wr(hup_reg_ctrl, 32'h1);
		check(pins_assigned, 1'b1);
		wr(hup_reg_data, 32'h4B);
		wait_rx(1);
		check(host_u.got_byte, 8'h4B);
		$display("test default_tx done");
	endtask : t_default_tx
	task automatic t_duplex;
		wr(hup_reg_baud, 32'h2);
		host_bit = 32'd32;
		fork
			host_u.send(8'h3C, 1'b1);
			wr(hup_reg_data, 32'hC3);
		join
		wait_rx(2);
		check(host_u.got_byte, 8'hC3);
		rd(hup_reg_data, 32'h3C, 32'hFF);
		$display("test duplex done");
	endtask : t_duplex
	task automatic t_errors;
		host_u.send(8'h11, 1'b1);
		host_u.send(8'h22, 1'b1);
		repeat (1600) @(posedge clk_sys);
		host_u.send(8'h55, 1'b0);
		repeat (40) @(posedge clk_sys);
		rd(hup_reg_status, 32'h1C, 32'h1C);
		wr(hup_reg_status, 32'h1C);
		rd(hup_reg_data, 32'h55, 32'hFF);
		rd(hup_reg_status, 32'h0, 32'h1D);
		$display("test errors done");
	endtask : t_errors
	task automatic t_flow;
		int n;
		wr(hup_reg_ctrl, 32'h3);
		check(rx_flow_request_n, 1'b0);
		n = host_u.got_count;
		tx_clear_n <= 1'b1;
		wr(hup_reg_data, 32'h5A);
		repeat (640) @(posedge clk_sys);
		check(host_u.got_count, n);
		tx_clear_n <= 1'b0;
		wait_rx(n + 1);
		check(host_u.got_byte, 8'h5A);
		host_u.send(8'h99, 1'b1);
		repeat (20) @(posedge clk_sys);
		check(rx_flow_request_n, 1'b1);
		rd(hup_reg_data, 32'h99, 32'hFF);
		$display("test flow done");
	endtask : t_flow
	task automatic t_gap;
		int n;
		longint s1;
		wr(hup_reg_gap, 32'h2);
		wr(hup_reg_ctrl, 32'h21);
		n = host_u.got_count;
		wr(hup_reg_data, 32'h01);
		wr(hup_reg_data, 32'h02);
		wait_rx(n + 1);
		s1 = host_u.got_start;
		wait_rx(n + 2);
		check(host_u.got_start - s1 >= 960, 1'b1);
		check(host_u.got_byte, 8'h02);
		$display("test gap done");
	endtask : t_gap
	task automatic t_wake;
		int n;
		int k;
		longint tw;
		wr(hup_reg_wake, 32'd400);
		wr(hup_reg_ctrl, 32'h5);
		n = host_u.got_count;
		wr(hup_reg_data, 32'h77);
		for (k = 0; k < 50 && host_wake !== 1'b1; k++) @(posedge clk_sys);
		tw = host_u.cyc;
		check(host_wake, 1'b1);
		wait_rx(n + 1);
		check(host_u.got_start - tw >= 400, 1'b1);
		$display("test wake done");
	endtask : t_wake
	task automatic t_second;
		int n;
		wr(hup_reg_ctrl, 32'h19);
		host_bit = 32'd2608;
		n = host_u.got_count;
		wr(hup_reg_data, 32'hE1);
		check(sec_tx_oe, 1'b1);
		wait_rx(n + 1);
		check(host_u.got_byte, 8'hE1);
		host_u.send(8'h1E, 1'b1);
		repeat (10) @(posedge clk_sys);
		rd(hup_reg_data, 32'h1E, 32'hFF);
		wr(hup_reg_ctrl, 32'h1);
		check(sec_tx_oe, 1'b0);
		$display("test second done");
	endtask : t_second
	// ----------------------------------------
	// Run control
	// ----------------------------------------
	task automatic results;
		$display("checks %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : results
	// Longest path is two slow frames, well under this span
	initial begin
		repeat (100000) @(posedge clk_sys);
		miscompares++;
		results();
	end
	initial begin
		repeat (20) @(posedge clk_sys);
		reset <= 1'b0;
		t_reset_regs();
		t_default_tx();
		t_duplex();
		t_errors();
		t_flow();
		t_gap();
		t_wake();
		t_second();
		results();
	end
endmodule : hup_core_bench
